// [core/psp_stage_positioner.sv]
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "psp_cfg.svh"
module psp_stage_positioner #(
	parameter int unsigned CYC_PER_MS = `PSP_CLK_HZ / `PSP_MS_PER_S,
	parameter int unsigned LAMP_CYC   = `PSP_LAMP_MS * CYC_PER_MS,
	parameter int unsigned HOLD_CYC   = `PSP_HOLD_MS * CYC_PER_MS
) (
	input  wire logic               core_clk, // 10 MHz system clock
	input  wire logic               arst_n,   // async reset, low
	input  wire psp_pkg::psp_pins_t pins,     // panel, sensors, switches
	output psp_pkg::psp_out_t       drv,      // step, dir and lamps
	input  wire logic               cyc_i,    // wishbone cycle
	input  wire logic               stb_i,    // wishbone strobe
	input  wire logic               we_i,     // wishbone write
	input  wire logic [7:0]         adr_i,    // wishbone byte address
	input  wire logic [3:0]         sel_i,    // wishbone byte lanes
	input  wire logic [31:0]        dat_i,    // wishbone write data
	output logic [31:0]             dat_o,    // wishbone read data
	output logic                    ack_o     // wishbone acknowledge
);

	localparam int PW = $bits(psp_pkg::psp_pins_t);
	localparam psp_pkg::psp_state_t ST_RST = '{
		phase: psp_pkg::PH_LAMP,
		ctrl: `PSP_CTRL_RST,
		default: '0
	};

	generate
		if (CYC_PER_MS < 2 || LAMP_CYC < 1 || HOLD_CYC < 2) begin : g_chk
			$error("psp_stage_positioner: timing counts too small");
		end
	endgenerate

	psp_pkg::psp_state_t q;
	psp_pkg::psp_state_t n;

	// position slots stay out of reset: they model the retained store
	logic signed [31:0] slotMem [`PSP_SLOTS];
	logic               memWe;
	logic [2:0]         memIdx;

	////////////////////////////////////////////////////////////////////
	// input qualification: a change counts once stages 2 and 3 agree

	logic [PW-1:0] s2V;
	logic [PW-1:0] s3V;
	logic [PW-1:0] fltV;
	logic [PW-1:0] fltNextV;

	assign s2V  = q.s2;
	assign s3V  = q.s3;
	assign fltV = q.flt;

	generate
		for (genvar gi = 0; gi < PW; gi++) begin : g_flt
			assign fltNextV[gi] = (s2V[gi] == s3V[gi]) ? s3V[gi] : fltV[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// settings as currently set on the switches

	psp_pkg::psp_cfg_t cfgNow;
	logic [1:0]        pprIdx;
	logic [`PSP_MULT_W*16-1:0] multTab;
	logic [`PSP_RAMP_W*16-1:0] rampTab;
	logic [`PSP_TOP_W*16-1:0]  topTab;
	logic [`PSP_PPR_W*4-1:0]   pprTab;

	assign multTab = `PSP_MULT_TAB;
	assign rampTab = `PSP_RAMP_TAB;
	assign topTab  = `PSP_TOP_TAB;
	assign pprTab  = `PSP_PPR_TAB;
	assign pprIdx  = 2'(q.flt.rotationPulsesSwitch - `PSP_ROT_FIRST);

	always_comb begin
		cfgNow.mult   = multTab[q.flt.multiplierSwitch*`PSP_MULT_W +:
			`PSP_MULT_W]; // R01
		cfgNow.rampMs = rampTab[q.flt.rampTimeSwitch*`PSP_RAMP_W +:
			`PSP_RAMP_W]; // R03
		cfgNow.topF   = topTab[q.flt.topSpeedSwitch*`PSP_TOP_W +:
			`PSP_TOP_W];
		cfgNow.linear = q.flt.rotationPulsesSwitch == `PSP_ROT_LINEAR;
		cfgNow.ok     = cfgNow.linear ||
			(q.flt.rotationPulsesSwitch >= `PSP_ROT_FIRST &&
			q.flt.rotationPulsesSwitch <= `PSP_ROT_LAST); // R04
		cfgNow.ppr    = '0;
		if (cfgNow.ok && !cfgNow.linear) begin
			cfgNow.ppr = pprTab[pprIdx*`PSP_PPR_W +: `PSP_PPR_W]; // R04
		end
	end

	////////////////////////////////////////////////////////////////////
	// derived rates from the captured settings and the trims

	logic [22:0] topR;
	logic [30:0] startProd;
	logic [22:0] startR;
	logic [22:0] incR;
	logic [22:0] incQ;
	logic [25:0] total;
	logic signed [31:0] totalS;
	logic [15:0] blCnt;

	always_comb begin
		topR      = {7'h0, q.cfg.topF} * {15'h0, q.cfg.mult}; // R01
		startProd = {8'h0, topR} * {23'h0, q.ctrl[`PSP_CTRL_START]};
		startR    = {1'b0, startProd[30:`PSP_START_SHIFT]}; // R08
		incQ      = (topR - startR) / {13'h0, q.cfg.rampMs}; // R03
		incR      = (incQ == '0) ? 23'h1 : incQ;
		// a zero start ratio would stall the move once deceleration brings the rate down to it
		if (startR < incR) begin
			startR = incR;
		end
		total  = {8'h0, q.cfg.ppr} * {18'h0, q.cfg.mult}; // R05
		totalS = {6'h0, total};
		blCnt  = {8'h0, q.ctrl[`PSP_CTRL_BL]} * {8'h0, q.cfg.mult}; // R09
	end

	////////////////////////////////////////////////////////////////////
	// next-state logic

	psp_pkg::psp_pins_t rise;
	logic               msTick;
	logic               launch;
	logic               lDir;
	logic               lOrigin;
	logic [31:0]        lCnt;
	logic [15:0]        lBl;
	logic [2:0]         heldIdx;
	logic               canStore;
	logic signed [31:0] tgt;
	logic [32:0]        diff;
	logic [31:0]        mag;
	logic               blocked;
	logic               decel;
	logic [24:0]        accSum;
	logic signed [31:0] nextPos;
	logic [31:0]        rdData;
	psp_pkg::psp_status_t stat;

	always_comb begin
		n        = q;
		memWe    = 1'b0;
		memIdx   = q.holdSlot;
		launch   = 1'b0;
		lDir     = 1'b0;
		lOrigin  = 1'b0;
		lCnt     = '0;
		lBl      = '0;
		heldIdx  = '0;
		tgt      = slotMem[q.holdSlot];
		diff     = {tgt[31], tgt} - {q.pos[31], q.pos};
		mag      = diff[32] ? 32'(-diff) : diff[31:0];
		accSum   = {1'b0, q.acc} + {2'b0, q.rate};
		blocked  = q.cfg.linear &&
			(q.dir ? q.flt.limitPos : q.flt.limitNeg); // R07
		decel    = !q.homing && q.remain <= q.accSteps;
		canStore = !q.flt.writeProtectSwitch && q.posValid &&
			q.pos >= `PSP_POS_MIN && q.pos <= `PSP_POS_MAX; // R02 R17
		rdData   = '0;
		stat     = '0;

		n.s1  = pins;
		n.s2  = q.s1;
		n.s3  = q.s2;
		n.flt = psp_pkg::psp_pins_t'(fltNextV);
		rise  = psp_pkg::psp_pins_t'(fltNextV & ~fltV);

		n.blink  = q.blink + 22'h1;
		msTick   = q.msCnt == CYC_PER_MS - 1;
		n.msCnt  = msTick ? '0 : q.msCnt + 32'h1;
		n.out.step = 1'b0;

		for (int i = `PSP_SLOTS - 1; i >= 0; i--) begin
			if (q.flt.posBtn[i]) begin
				heldIdx = 3'(i);
			end
		end

		// wrap for rotary stages, plain count for linear
		if (q.dir) begin
			nextPos = q.pos + 32'sh1; // R22
			if (!q.cfg.linear && q.pos == totalS - 32'sh1) begin
				nextPos = '0; // R06
			end
		end else begin
			nextPos = q.pos - 32'sh1; // R22
			if (!q.cfg.linear && q.pos == '0) begin
				nextPos = totalS - 32'sh1; // R06
			end
		end

		unique case (q.phase)
			psp_pkg::PH_LAMP: begin
				n.out.originLamp = 1'b1;
				n.out.posLamp    = '1;
				n.tmr            = q.tmr + 32'h1;
				if (q.tmr == LAMP_CYC - 1) begin // R11
					n.cfg            = cfgNow;
					n.tmr            = '0;
					n.out.originLamp = 1'b0;
					n.out.posLamp    = '0;
					n.phase = cfgNow.ok ? psp_pkg::PH_IDLE
						: psp_pkg::PH_BADCFG;
				end
			end
			psp_pkg::PH_BADCFG: begin
				// stays here: settings only take effect at power-up
				n.out.originLamp = q.blink[`PSP_BLINK_FAST]; // R11
				n.out.posLamp    = {5{q.blink[`PSP_BLINK_FAST]}};
			end
			psp_pkg::PH_IDLE: begin
				n.out.posLamp = q.litSlot;
				if (!q.flt.operationModeSelector) begin // R16
					n.holdCnt = '0;
					n.stored  = 1'b0;
				end else if (rise.originBtn) begin
					launch  = 1'b1; // R12
					lOrigin = 1'b1;
				end else if (|q.flt.posBtn) begin
					n.holdSlot = heldIdx;
					if (!q.stored) begin
						n.holdCnt     = q.holdCnt + 32'h1;
						n.out.posLamp = 5'({4'h0,
							q.blink[`PSP_BLINK_SLOW]} << heldIdx); // R14
						if (q.holdCnt == HOLD_CYC - 1) begin
							n.stored      = 1'b1; // R14
							memWe         = canStore;
							memIdx        = heldIdx;
							n.litSlot     = 5'(5'h1 << heldIdx);
							n.out.posLamp = n.litSlot;
						end
					end
				end else if (q.holdCnt != '0 || q.stored) begin
					n.holdCnt = '0;
					n.stored  = 1'b0;
					if (q.stored) begin
						n.litSlot = '0;
					end else if (!q.homeOk) begin
						launch  = 1'b1; // R13
						lOrigin = 1'b1;
					end else begin
						n.litSlot        = 5'(5'h1 << q.holdSlot); // R15
						n.out.originLamp = 1'b0;
						lDir             = !diff[32];
						lCnt             = mag;
						if (blCnt != '0 && lDir == q.flt.backlashReverse)
						begin
							lCnt = mag + {16'h0, blCnt}; // R09
							lBl  = blCnt;
						end
						launch = lCnt != '0;
					end
				end else if (rise.knobStep && !q.flt.knobLockSwitch &&
					q.ctrl[`PSP_CTRL_GAIN] != '0) begin
					launch = 1'b1; // R19
					lDir   = q.flt.knobDir ^ q.flt.knobReverse; // R19
					lCnt   = {24'h0, q.ctrl[`PSP_CTRL_GAIN]}; // R10
				end
			end
			psp_pkg::PH_MOVE: begin
				if (msTick) begin
					if (decel) begin
						n.rate = (q.rate > q.start + q.inc) ?
							q.rate - q.inc : q.start;
					end else if (q.rate < q.top) begin
						n.rate = (q.top - q.rate > q.inc) ?
							q.rate + q.inc : q.top;
					end
				end
				if (accSum >= {1'b0, `PSP_CLK_HZ}) begin
					n.acc = 24'(accSum - {1'b0, `PSP_CLK_HZ});
				end else begin
					n.acc = accSum[23:0];
				end
				if (q.homing && q.flt.originSensor) begin
					n.pos      = '0; // R12
					n.posValid = 1'b1;
					n.homeOk   = 1'b1;
					n.phase    = psp_pkg::PH_IDLE;
				end else if (q.remain == '0 || blocked) begin
					n.phase = psp_pkg::PH_IDLE;
					if (q.blPend != '0 && !blocked) begin
						// second leg always approaches from one side
						n.phase    = psp_pkg::PH_MOVE;
						n.dir      = !q.dir; // R09
						n.out.dir  = !q.dir;
						n.remain   = {16'h0, q.blPend};
						n.blPend   = '0;
						n.rate     = q.start;
						n.acc      = '0;
						n.accSteps = '0;
					end
				end else if (accSum >= {1'b0, `PSP_CLK_HZ}) begin
					n.out.step = 1'b1;
					n.pos      = nextPos; // R22
					n.remain   = q.remain - 32'h1;
					if (!decel && q.rate < q.top) begin
						n.accSteps = q.accSteps + 32'h1;
					end
				end
			end
		endcase

		// stop is honoured in any mode once running
		if (rise.stopBtn && (q.phase == psp_pkg::PH_IDLE ||
			q.phase == psp_pkg::PH_MOVE)) begin
			launch     = 1'b0;
			n.phase    = psp_pkg::PH_IDLE; // R18
			n.out.step = 1'b0;
			n.remain   = '0;
			n.blPend   = '0;
			n.homeOk   = 1'b0; // R13
			n.out.originLamp = 1'b0;
			if (q.phase == psp_pkg::PH_MOVE) begin
				n.posValid = 1'b0; // R18
			end
		end

		if (launch) begin
			n.phase    = psp_pkg::PH_MOVE;
			n.dir      = lDir;
			n.out.dir  = lDir;
			n.remain   = lOrigin ? '1 : lCnt;
			n.homing   = lOrigin;
			n.blPend   = lBl;
			n.rate     = startR; // R08
			n.start    = startR;
			n.top      = topR;
			n.inc      = incR;
			n.acc      = '0;
			n.accSteps = '0;
			if (lOrigin) begin
				n.out.originLamp = 1'b1; // R12
				n.litSlot        = '0;
				n.out.posLamp    = '0;
			end
		end

		// register slave: one wait state, every address answered
		stat.busy       = q.phase == psp_pkg::PH_MOVE;
		stat.homing     = q.homing && stat.busy;
		stat.holdStored = q.stored;
		stat.cfgOk      = q.cfg.ok;
		stat.homeOk     = q.homeOk;
		stat.posValid   = q.posValid;
		if (adr_i == `PSP_REG_CTRL) begin
			rdData = {8'h0, q.ctrl};
		end else if (adr_i == `PSP_REG_STAT) begin
			rdData = stat;
		end else if (adr_i == `PSP_REG_POS) begin
			rdData = q.pos;
		end else if (adr_i == `PSP_REG_TOTAL) begin
			rdData = {6'h0, total};
		end else if (adr_i >= `PSP_REG_SLOT0 && adr_i <= `PSP_REG_SLOTN &&
			adr_i[1:0] == 2'h0) begin
			rdData = slotMem[3'(adr_i[7:2] - `PSP_REG_SLOT0 / 4)];
		end
		n.wbAck = 1'b0;
		if (cyc_i && stb_i && !q.wbAck) begin
			n.wbAck = 1'b1;
			n.wbDat = rdData;
			if (we_i && adr_i == `PSP_REG_CTRL) begin
				for (int b = 0; b < `PSP_CTRL_BYTES; b++) begin
					if (sel_i[b]) begin
						n.ctrl[b*8 +: 8] = dat_i[b*8 +: 8];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// state and retained store

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= ST_RST;
		end else begin
			q <= n;
		end
	end

	always_ff @(posedge core_clk) begin
		if (memWe) begin
			slotMem[memIdx] <= q.pos; // R17
		end
	end

	assign drv   = q.out;
	assign dat_o = q.wbDat;
	assign ack_o = q.wbAck;

endmodule

// [pkg/psp_cfg.svh]
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH
// Summary of operation
// [R01] multiplier switch scales speed, rotation, backlash
// [R02] stored coordinates limited to -1M .. +15M
// [R03] ramp-time switch selects accel/decel time
// [R04] code 0 linear, codes 2-5 rotary pulses
// [R05] pulses per revolution times multiplier
// [R06] rotary position wraps modulo revolution count
// [R07] linear stage never steps past a limit
// [R08] start speed 0..50% of top speed
// [R09] backlash trim times multiplier, zero disables
// [R10] knob gain not scaled by multiplier
// [R11] lamps lit one second, fast blink if invalid
// [R12] origin switch homes stage, lamp stays lit
// [R13] first positioning press after reset/stop homes
// [R14] hold positioning switch: blink, store, steady
// [R15] short press moves to stored coordinate
// [R16] positioning switches only in front-panel mode
// [R17] slots survive power loss, write-protect blocks
// [R18] stop halts at once, motion invalidates position
// [R19] knob jogs in front-panel mode, lock, reverse
// [R20] multiplier should match driver micro-step division
// [R21] top speed times multiplier within 500k pps (not enforced: the switch tables allow up to 5M pps)
// [R22] signed position counts one per step

`define PSP_CLK_HZ 24'h989680
`define PSP_MS_PER_S 32'h000003e8
`define PSP_LAMP_MS 32'h000003e8
`define PSP_HOLD_MS 32'h000003e8
`define PSP_BLINK_SLOW 21
`define PSP_BLINK_FAST 19
`define PSP_START_SHIFT 9
`define PSP_POS_MIN (-32'sh000f4240)
`define PSP_POS_MAX 32'sh00e4e1c0
`define PSP_ROT_LINEAR 4'h0
`define PSP_ROT_FIRST 4'h2
`define PSP_ROT_LAST 4'h5
`define PSP_MULT_TAB {8'hfa, 8'hc8, 8'h7d, 8'h64, 8'h32, 8'h19, \
	8'h10, 8'h50, 8'h28, 8'h14, 8'h0a, 8'h08, 8'h05, 8'h04, 8'h02, 8'h01}
`define PSP_RAMP_TAB {10'h3e8, 10'h320, 10'h2bc, 10'h258, 10'h1f4, \
	10'h190, 10'h15e, 10'h12c, 10'h0fa, 10'h0c8, 10'h0b4, 10'h096, \
	10'h078, 10'h064, 10'h032, 10'h014}
`define PSP_TOP_TAB {16'h4e20, 16'h4268, 16'h3a98, 16'h32c8, \
	16'h2af8, 16'h2710, 16'h2328, 16'h1f40, 16'h1b58, 16'h1770, \
	16'h1388, 16'h0fa0, 16'h0bb8, 16'h07d0, 16'h03e8, 16'h01f4}
`define PSP_PPR_TAB {18'h23280, 18'h11940, 18'h08ca0, 18'h07530}
`define PSP_MULT_W 8
`define PSP_RAMP_W 10
`define PSP_TOP_W 16
`define PSP_PPR_W 18
`define PSP_REG_CTRL 8'h00
`define PSP_REG_STAT 8'h04
`define PSP_REG_POS 8'h08
`define PSP_REG_TOTAL 8'h0c
`define PSP_REG_SLOT0 8'h10
`define PSP_REG_SLOTN 8'h20
`define PSP_CTRL_RST 24'h010000
`define PSP_CTRL_START 7:0
`define PSP_CTRL_BL 15:8
`define PSP_CTRL_GAIN 23:16
`define PSP_CTRL_BYTES 3
`define PSP_SLOTS 5
`endif

// [pkg/psp_pkg.sv]
package psp_pkg;

	typedef enum logic [1:0] {PH_LAMP, PH_BADCFG, PH_IDLE, PH_MOVE}
		psp_phase_t;

	typedef struct packed {
		logic       originBtn;
		logic       stopBtn;
		logic [4:0] posBtn;
		logic       knobStep;
		logic       knobDir;
		logic       originSensor;
		logic       limitPos;
		logic       limitNeg;
		logic       operationModeSelector;
		logic       writeProtectSwitch;
		logic       knobLockSwitch;
		logic       knobReverse;
		logic       backlashReverse;
		logic [3:0] multiplierSwitch;
		logic [3:0] rampTimeSwitch;
		logic [3:0] rotationPulsesSwitch;
		logic [3:0] topSpeedSwitch;
	} psp_pins_t;

	typedef struct packed {
		logic       step;
		logic       dir;
		logic       originLamp;
		logic [4:0] posLamp;
	} psp_out_t;

	typedef struct packed {
		logic [7:0]  mult;
		logic [9:0]  rampMs;
		logic [17:0] ppr;
		logic [15:0] topF;
		logic        linear;
		logic        ok;
	} psp_cfg_t;

	typedef struct packed {
		logic [25:0] zero;
		logic        busy;
		logic        homing;
		logic        holdStored;
		logic        cfgOk;
		logic        homeOk;
		logic        posValid;
	} psp_status_t;

	typedef struct packed {
		psp_phase_t         phase;
		psp_pins_t          s1;
		psp_pins_t          s2;
		psp_pins_t          s3;
		psp_pins_t          flt;
		logic [31:0]        tmr;
		logic [31:0]        msCnt;
		logic [21:0]        blink;
		psp_cfg_t           cfg;
		logic signed [31:0] pos;
		logic [31:0]        remain;
		logic               dir;
		logic               homing;
		logic [15:0]        blPend;
		logic [22:0]        rate;
		logic [22:0]        top;
		logic [22:0]        start;
		logic [22:0]        inc;
		logic [23:0]        acc;
		logic [31:0]        accSteps;
		logic               posValid;
		logic               homeOk;
		logic               stored;
		logic [2:0]         holdSlot;
		logic [31:0]        holdCnt;
		logic [4:0]         litSlot;
		logic [23:0]        ctrl;
		logic               wbAck;
		logic [31:0]        wbDat;
		psp_out_t           out;
	} psp_state_t;

endpackage

// [test/psp_stage_model.sv]
`timescale 1ns/1ps
module psp_stage_model #(
	parameter int START   = 5,
	parameter int NEG_LIM = -20,
	parameter int POS_LIM = 1000
) (
	input  wire logic              core_clk,     // system clock
	input  wire psp_pkg::psp_out_t drv,          // step and direction
	output logic                   originSensor, // home flag
	output logic                   limitPos,     // positive end switch
	output logic                   limitNeg      // negative end switch
);
	// the carriage is not reset with the controller: it stays where it was
	int ph = START;

	always_ff @(posedge core_clk) begin
		if (drv.step) begin
			ph <= drv.dir ? ph + 1 : ph - 1;
		end
	end

	// flag covers zero and below, so homing from any side above stops at 0
	assign originSensor = ph <= 0;
	assign limitPos     = ph >= POS_LIM;
	assign limitNeg     = ph <= NEG_LIM;
endmodule

// [test/psp_stage_positioner_properties.sv]
`timescale 1ns/1ps
module psp_stage_checker #(
	parameter int unsigned CYC_PER_MS = 4,
	parameter int unsigned LAMP_CYC   = 20,
	parameter int unsigned HOLD_CYC   = 40
) (
	input wire logic               core_clk, // clock
	input wire logic               arst_n,   // reset
	input wire psp_pkg::psp_pins_t pins,     // panel pins
	input wire psp_pkg::psp_out_t  drv,      // driver and lamps
	input wire logic               cyc_i,    // bus cycle
	input wire logic               stb_i,    // bus strobe
	input wire logic               we_i,     // bus write
	input wire logic [7:0]         adr_i,    // bus address
	input wire logic [3:0]         sel_i,    // bus lanes
	input wire logic [31:0]        dat_i,    // bus write data
	input wire logic [31:0]        dat_o,    // bus read data
	input wire logic               ack_o     // bus acknowledge
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_stop_held;
		pins.stopBtn [*8];
	endsequence
	sequence s_lamp_on;
		drv.originLamp && drv.posLamp == 5'h1f && !drv.step;
	endsequence

	a_ack_next_cycle: assert property (s_req |=> ack_o)
		else $error("bus request not answered in one cycle");
	a_ack_single_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_ack_has_request: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without a request");
	a_unmapped_read_zero: assert property (
		s_req ##0 (!we_i && adr_i == 8'h40) |=> dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_step_one_cycle: assert property (drv.step |=> !drv.step)
		else $error("step pulse wider than one cycle");
	a_limit_blocks_step: assert property (
		(pins.limitNeg && pins.rotationPulsesSwitch == 4'h0) [*5]
		|-> !(drv.step && !drv.dir))
		else $error("step into the negative limit");
	a_stop_halts_steps: assert property (s_stop_held |-> !drv.step)
		else $error("step while stop held");
	a_lamp_test_on: assert property ($rose(arst_n) |=> s_lamp_on [*8])
		else $error("lamp check missing after reset");
endmodule

bind psp_stage_positioner psp_stage_checker #(
	.CYC_PER_MS(CYC_PER_MS),
	.LAMP_CYC  (LAMP_CYC),
	.HOLD_CYC  (HOLD_CYC)
) u_chk (
	.core_clk(core_clk),
	.arst_n  (arst_n),
	.pins    (pins),
	.drv     (drv),
	.cyc_i   (cyc_i),
	.stb_i   (stb_i),
	.we_i    (we_i),
	.adr_i   (adr_i),
	.sel_i   (sel_i),
	.dat_i   (dat_i),
	.dat_o   (dat_o),
	.ack_o   (ack_o)
);

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
	localparam int LAMP = 20;
	localparam int HOLD = 40;
	psp_pkg::psp_pins_t pb;
	psp_pkg::psp_pins_t pinsW;
	psp_pkg::psp_out_t  drv;
	logic        clk;
	logic        rstN;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        ack;
	logic        org;
	logic        limP;
	logic        limN;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdOut;
	logic [31:0] rdat;
	int          nFail;
	int          totalChecks;
	int          gain;
	int          nSteps = 0;
	int          steps0;
	logic [7:0]  mt [16] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h0a,
		8'h14, 8'h28, 8'h50, 8'h10, 8'h19, 8'h32, 8'h64, 8'h7d, 8'hc8, 8'hfa};
	logic [31:0] ppr [4] = '{32'h7530, 32'h8ca0, 32'h11940, 32'h23280};

	initial clk = 1'b0;
	always #50 clk = ~clk;

	always_comb begin
		pinsW              = pb;
		pinsW.originSensor = org;
		pinsW.limitPos     = limP;
		pinsW.limitNeg     = limN;
	end

	psp_stage_positioner #(.CYC_PER_MS(4), .LAMP_CYC(LAMP), .HOLD_CYC(HOLD))
	DUT (.core_clk(clk), .arst_n(rstN), .pins(pinsW), .drv(drv), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
		.dat_o(rdOut), .ack_o(ack));

	psp_stage_model stage (.core_clk(clk), .drv(drv), .originSensor(org),
		.limitPos(limP), .limitNeg(limN));

	// every emitted step, for the counted-move checks
	always @(posedge clk) begin
		if (drv.step === 1'b1) nSteps <= nSteps + 1;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			nFail++;
		end
	endtask

	// no local limit: a slave that never answers is left to the watchdog
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= 4'hf;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rdat = rdOut;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		wb(1'b0, a, 32'h0);
	endtask

	task automatic posIs(input logic [31:0] exp);
		rd(8'h08);
		chk(rdat, exp);
	endtask

	// status polled over the bus, so the wait also exercises reads
	task automatic waitIdle;
		do begin
			rd(8'h04);
		end while (rdat[5] !== 1'b0);
	endtask

	task automatic setBtn(input int b, input logic v);
		case (b)
			5: pb.originBtn <= v;
			6: pb.stopBtn <= v;
			7: pb.knobStep <= v;
			default: pb.posBtn[b] <= v;
		endcase
	endtask

	task automatic press(input int b, input int n);
		setBtn(b, 1'b1);
		tick(n);
		setBtn(b, 1'b0);
		tick(8);
	endtask

	task automatic jog(input logic d);
		// direction and lock are levels: let them settle before the detent
		pb.knobDir <= d;
		tick(8);
		press(7, 6);
		waitIdle();
	endtask

	// settings are only taken at the end of the lamp check, hence a reset
	task automatic reset_to(input logic [3:0] m, input logic [3:0] r);
		pb.multiplierSwitch     <= m;
		pb.rotationPulsesSwitch <= r;
		rstN <= 1'b0;
		tick(20);
		rstN <= 1'b1;
		tick(2);
		chk(32'({drv.originLamp, drv.posLamp}), 32'h3f);
		tick(LAMP + 8);
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (95000) @(posedge clk);
		nFail++;
		tally_and_finish();
	end

	initial begin
		pb = '0;
		pb.operationModeSelector = 1'b1;
		pb.topSpeedSwitch = 4'hf;
		{cyc, stb, we, adr, sel, wdat, rstN} = '0;
		sel = 4'hf;
		nFail = 0;
		totalChecks = 0;
		void'($urandom(32'ha9c300de));
		for (int m = 0; m < 16; m++) begin
			logic [3:0] r;
			r = 4'h2 + 4'($urandom % 4);
			if (32'(mt[m]) * ppr[r - 2] > 32'he4e1c0) r = 4'h2;
			reset_to(4'(m), r);
			rd(8'h0c);
			chk(rdat, 32'(mt[m]) * ppr[r - 2]);
		end
		reset_to(4'h5, 4'h4);
		chk(32'({drv.originLamp, drv.posLamp}), 32'h0);
		rd(8'h40);
		chk(rdat, 32'h0);
		gain = 1 + int'($urandom % 8);
		wb(1'b1, 8'h00, {8'h0, 8'(gain), 16'h0});
		press(0, 6);
		waitIdle();
		posIs(32'h0);
		chk(32'(drv.originLamp), 32'h1);
		jog(1'b0);
		posIs(32'h000afc80 - 32'(gain));
		jog(1'b1);
		jog(1'b1);
		posIs(32'(gain));
		setBtn(2, 1'b1);
		tick(HOLD + 20);
		chk(32'(drv.posLamp[2]), 32'h1);
		setBtn(2, 1'b0);
		tick(8);
		rd(8'h18);
		chk(rdat, 32'(gain));
		jog(1'b1);
		press(2, 6);
		waitIdle();
		posIs(32'(gain));
		chk(32'(drv.posLamp), 32'h04);
		jog(1'b1);
		pb.writeProtectSwitch <= 1'b1;
		setBtn(2, 1'b1);
		tick(HOLD + 20);
		setBtn(2, 1'b0);
		tick(8);
		rd(8'h18);
		chk(rdat, 32'(gain));
		pb.writeProtectSwitch <= 1'b0;
		pb.operationModeSelector <= 1'b0;
		press(2, 6);
		waitIdle();
		jog(1'b0);
		posIs(32'(2 * gain));
		pb.operationModeSelector <= 1'b1;
		wb(1'b1, 8'h00, {8'h0, 8'(gain), 8'h01, 8'h00});
		steps0 = nSteps;
		press(2, 6);
		waitIdle();
		posIs(32'(gain));
		chk(32'(nSteps - steps0), 32'(gain + 2 * int'(mt[5])));
		jog(1'b1);
		press(2, 6);
		tick(120);
		press(6, 10);
		steps0 = nSteps;
		tick(200);
		chk(32'(nSteps - steps0), 32'h0);
		rd(8'h04);
		chk(32'(rdat[2:0]), 32'h4);
		press(2, 6);
		waitIdle();
		posIs(32'h0);
		chk(32'(drv.originLamp), 32'h1);
		reset_to(4'h5, 4'h1);
		press(0, 6);
		rd(8'h04);
		chk(32'(rdat[5:2]), 32'h0);
		chk(32'({drv.originLamp, drv.posLamp}), 32'h0);
		reset_to(4'h5, 4'h0);
		wb(1'b1, 8'h00, {8'h0, 8'h1e, 16'h0});
		jog(1'b0);
		posIs(32'hffffffec);
		pb.knobLockSwitch <= 1'b1;
		jog(1'b1);
		posIs(32'hffffffec);
		tally_and_finish();
	end
endmodule
